// >>> stop_ctrl_pkg.sv
package stop_ctrl_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [5:0] OFS_CTRL      = 6'h00;
    localparam logic [5:0] OFS_DECEL     = 6'h04;
    localparam logic [5:0] OFS_JERK      = 6'h08;
    localparam logic [5:0] OFS_ADD_DIST  = 6'h0c;
    localparam logic [5:0] OFS_ADD_VEL   = 6'h10;
    localparam logic [5:0] OFS_BASE_DIST = 6'h14;
    localparam logic [5:0] OFS_BASE_VEL  = 6'h18;
    localparam logic [5:0] OFS_STATUS    = 6'h1c;
    localparam logic [5:0] OFS_FAULT     = 6'h20;
    localparam logic [5:0] OFS_POSITION  = 6'h24;
    localparam logic [5:0] OFS_VELOCITY  = 6'h28;
    localparam logic [5:0] OFS_ACCEL     = 6'h2c;

    // control register fields
    localparam int CTL_STOP_EXEC = 0;
    localparam int CTL_ADD_EXEC  = 1;
    localparam int CTL_BASE_EXEC = 2;
    localparam int CTL_AXIS_EN   = 3;
    localparam int CTL_BASE_BUF  = 4;
    localparam int CTL_AXIS_LSB  = 8;
    localparam int CTL_AXIS_W    = 6;

    // legal axis number range
    localparam logic [5:0] AXIS_MIN = 6'h01;
    localparam logic [5:0] AXIS_MAX = 6'h20;

    // fault codes, zero means no fault
    localparam logic [15:0] FC_NONE     = 16'h0000;
    localparam logic [15:0] FC_AXIS     = 16'h0001;
    localparam logic [15:0] FC_PARAM    = 16'h0002;
    localparam logic [15:0] FC_DISABLED = 16'h0003;
    localparam logic [15:0] FC_NO_ADD   = 16'h0004;

    // velocity ramp step of the moves, units per cycle squared
    localparam logic [31:0] ACC_STEP = 32'h0000_0001;
    localparam logic [31:0] ZERO32   = 32'h0000_0000;
endpackage

// >>> additive_move_stop.sv
// Overview of operation
// RQ1: axis 1..32, parameters sampled on start rise
// RQ2: caller gives positive deceleration and jerk
// RQ3: start only on rise, fall ignored
// RQ4: busy same cycle, active one later
// RQ5: active while stop controls the axis
// RQ6: done drops busy, active; holds till fall
// RQ7: done after fall lasts one cycle
// RQ8: abort sets aborted, drops busy, active
// RQ9: abort after fall: aborted one cycle
// RQ10: error on fault, held till fall
// RQ11: disabled axis: error, drop busy, active
// RQ12: error shows sixteen bit fault code
// RQ13: no additive move: stop never acts
// RQ14: stop aborts additive move, base untouched
// RQ15: commanded velocity, acceleration are sums
// RQ16: relative move references start position
// RQ17: additive move completes on own distance
// RQ18: final position start plus both distances
// RQ19: stop activation aborts additive move
// RQ20: jerk limited deceleration to zero
`timescale 1ns/1ps
`default_nettype none
module additive_move_stop
    import stop_ctrl_pkg::*;
#(
    parameter int DW = 32
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [5:0]    adr_i,
    input  wire logic [31:0]   dat_i,
    output logic      [31:0]   dat_o,
    input  wire logic          we_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic          stb_i,
    input  wire logic          cyc_i,
    output logic               ack_o,
    output logic               stop_busy_o,
    output logic               stop_active_o,
    output logic               stop_done_o,
    output logic               aborted_flag_o,
    output logic               stop_error_o,
    output logic      [15:0]   fault_code_o,
    output logic      [DW-1:0] cmd_position_o,
    output logic      [DW-1:0] cmd_velocity_o
);

    typedef struct packed {
        logic          ack;
        logic [31:0]   rdat;
        logic [31:0]   ctrl;
        logic [31:0]   decel;
        logic [31:0]   jerk;
        logic [31:0]   add_dist;
        logic [31:0]   add_tgt;
        logic [31:0]   base_dist;
        logic [31:0]   base_tgt;
        logic [2:0]    exec_prev;
        logic [DW-1:0] pos;
        logic          s_busy;
        logic          s_act;
        logic          s_done;
        logic          s_abt;
        logic          s_err;
        logic [15:0]   s_code;
        logic [31:0]   s_dec;
        logic [31:0]   s_jerk;
        logic [31:0]   s_rate;
        logic          a_busy;
        logic          a_act;
        logic          a_done;
        logic          a_abt;
        logic [DW-1:0] a_rem;
        logic [DW-1:0] a_vel;
        logic [DW-1:0] a_acc;
        logic          b_busy;
        logic          b_act;
        logic          b_done;
        logic [DW-1:0] b_ref;
        logic [DW-1:0] b_rem;
        logic [DW-1:0] b_vel;
        logic [DW-1:0] b_acc;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic          stop_ex;
    logic          add_ex;
    logic          base_ex;
    logic          stop_rise;
    logic          add_rise;
    logic          base_rise;
    logic          stop_go;
    logic [5:0]    axis_num;
    logic [15:0]   bad_code;
    logic          base_abort;
    logic [DW-1:0] a_step;
    logic [DW-1:0] b_step;

    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // start edges and parameter checks
    assign stop_ex  = st_q.ctrl[CTL_STOP_EXEC];
    assign add_ex   = st_q.ctrl[CTL_ADD_EXEC];
    assign base_ex  = st_q.ctrl[CTL_BASE_EXEC];
    // RQ3: rising edge only
    assign stop_rise = stop_ex & ~st_q.exec_prev[0];
    assign add_rise  = add_ex & ~st_q.exec_prev[1];
    assign base_rise = base_ex & ~st_q.exec_prev[2];
    assign axis_num  = st_q.ctrl[CTL_AXIS_LSB +: CTL_AXIS_W];
    // unbuffered base start aborts everything running on the axis
    assign base_abort = base_rise & ~st_q.ctrl[CTL_BASE_BUF];

    // RQ13: a missing additive move is a fault, checked last
    always_comb begin
        bad_code = FC_NONE;
        if (axis_num < AXIS_MIN || axis_num > AXIS_MAX) begin
            bad_code = FC_AXIS;
        end else if (st_q.decel == ZERO32 || st_q.jerk == ZERO32) begin
            bad_code = FC_PARAM;
        end else if (!st_q.ctrl[CTL_AXIS_EN]) begin
            bad_code = FC_DISABLED;
        end else if (!st_q.a_busy) begin
            bad_code = FC_NO_ADD;
        end
    end
    assign stop_go = stop_rise & (bad_code == FC_NONE) & ~base_abort;

    // distance covered this cycle, capped at the remaining distance except the additive part while the stop is active
    assign a_step = st_q.s_act ? st_q.a_vel :
                    (st_q.a_vel < st_q.a_rem ? st_q.a_vel : st_q.a_rem);
    assign b_step = st_q.b_vel < st_q.b_rem ? st_q.b_vel : st_q.b_rem;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        st_d = st_q;
        st_d.exec_prev = {base_ex, add_ex, stop_ex};

        // wishbone slave, one wait state, ack for one cycle
        st_d.ack = cyc_i & stb_i & ~st_q.ack;
        if (cyc_i && stb_i && !st_q.ack) begin
            unique case (adr_i)
                OFS_CTRL:      st_d.rdat = st_q.ctrl;
                OFS_DECEL:     st_d.rdat = st_q.decel;
                OFS_JERK:      st_d.rdat = st_q.jerk;
                OFS_ADD_DIST:  st_d.rdat = st_q.add_dist;
                OFS_ADD_VEL:   st_d.rdat = st_q.add_tgt;
                OFS_BASE_DIST: st_d.rdat = st_q.base_dist;
                OFS_BASE_VEL:  st_d.rdat = st_q.base_tgt;
                OFS_STATUS:    st_d.rdat = {20'h0_0000,
                                   st_q.b_act, st_q.b_busy, st_q.b_done,
                                   st_q.a_abt, st_q.a_act, st_q.a_busy,
                                   st_q.a_done, st_q.s_err, st_q.s_abt,
                                   st_q.s_act, stop_busy_o, st_q.s_done};
                OFS_FAULT:     st_d.rdat = {16'h0000, st_q.s_code};
                OFS_POSITION:  st_d.rdat = 32'(st_q.pos);
                OFS_VELOCITY:  st_d.rdat = 32'(st_q.a_vel + st_q.b_vel);
                OFS_ACCEL:     st_d.rdat = 32'(st_q.a_acc + st_q.b_acc);
                default:       st_d.rdat = ZERO32;
            endcase
            if (we_i) begin
                unique case (adr_i)
                    OFS_CTRL:      st_d.ctrl = merge(st_q.ctrl, dat_i, sel_i);
                    OFS_DECEL:     st_d.decel = merge(st_q.decel, dat_i, sel_i);
                    OFS_JERK:      st_d.jerk = merge(st_q.jerk, dat_i, sel_i);
                    OFS_ADD_DIST:  st_d.add_dist =
                                       merge(st_q.add_dist, dat_i, sel_i);
                    OFS_ADD_VEL:   st_d.add_tgt =
                                       merge(st_q.add_tgt, dat_i, sel_i);
                    OFS_BASE_DIST: st_d.base_dist =
                                       merge(st_q.base_dist, dat_i, sel_i);
                    OFS_BASE_VEL:  st_d.base_tgt =
                                       merge(st_q.base_tgt, dat_i, sel_i);
                    default: ;
                endcase
            end
        end

        // RQ18: position integrates both components exactly
        st_d.pos = st_q.pos + a_step + b_step;

        // flags held only while their start input stays high; a set
        // below overrides this clear
        // RQ7: RQ9: RQ10: one-cycle pulse once start has fallen
        st_d.s_done = st_q.s_done & stop_ex;
        st_d.s_abt  = st_q.s_abt & stop_ex;
        st_d.s_err  = st_q.s_err & stop_ex;
        st_d.a_done = st_q.a_done & add_ex;
        st_d.a_abt  = st_q.a_abt & add_ex;
        st_d.b_done = st_q.b_done & base_ex;

        // base relative move
        // RQ16: reference latched at start
        if (base_rise) begin
            st_d.b_busy = 1'b1;
            st_d.b_act  = 1'b1;
            st_d.b_done = 1'b0;
            st_d.b_ref  = st_q.pos;
            st_d.b_rem  = DW'(st_q.base_dist);
            st_d.b_vel  = '0;
            st_d.b_acc  = '0;
        end else if (st_q.b_act) begin
            st_d.b_rem = st_q.b_rem - b_step;
            st_d.b_vel = st_q.b_vel + st_q.b_acc;
            st_d.b_acc = (st_d.b_vel < DW'(st_q.base_tgt)) ? DW'(ACC_STEP)
                                                           : '0;
            if (st_d.b_rem == '0) begin
                st_d.b_busy = 1'b0;
                st_d.b_act  = 1'b0;
                st_d.b_done = 1'b1;
                st_d.b_vel  = '0;
                st_d.b_acc  = '0;
            end
        end

        // additive move, acceleration starts at zero
        // RQ15: ramp begins with zero acceleration
        if (add_rise && !base_abort) begin
            st_d.a_busy = 1'b1;
            st_d.a_act  = 1'b1;
            st_d.a_done = 1'b0;
            st_d.a_abt  = 1'b0;
            st_d.a_rem  = DW'(st_q.add_dist);
            st_d.a_vel  = '0;
            st_d.a_acc  = '0;
        end else if (st_q.a_act) begin
            // RQ17: completes on its own distance
            st_d.a_rem = st_q.a_rem - a_step;
            st_d.a_vel = st_q.a_vel + st_q.a_acc;
            st_d.a_acc = (st_d.a_vel < DW'(st_q.add_tgt)) ? DW'(ACC_STEP)
                                                          : '0;
            if (st_d.a_rem == '0) begin
                st_d.a_busy = 1'b0;
                st_d.a_act  = 1'b0;
                st_d.a_done = 1'b1;
                st_d.a_vel  = '0;
                st_d.a_acc  = '0;
            end
        end

        // stop instruction: start, checks and deceleration
        if (stop_go) begin
            // RQ1: parameters captured on the rising edge
            st_d.s_busy = 1'b1;
            st_d.s_act  = 1'b1;
            st_d.s_done = 1'b0;
            st_d.s_abt  = 1'b0;
            st_d.s_err  = 1'b0;
            st_d.s_code = FC_NONE;
            st_d.s_dec  = st_q.decel;
            st_d.s_jerk = st_q.jerk;
            st_d.s_rate = ZERO32;
            // RQ19: RQ14: additive move aborted, base move left alone
            st_d.a_busy = 1'b0;
            st_d.a_act  = 1'b0;
            st_d.a_done = 1'b0;
            st_d.a_abt  = 1'b1;
            st_d.a_acc  = '0;
        end else if (stop_rise && !base_abort) begin
            // RQ10: RQ12: illegal parameters or no move to stop
            // a restart that fails also gives up the running stop
            st_d.s_busy = 1'b0;
            st_d.s_act  = 1'b0;
            st_d.a_vel  = st_q.s_act ? '0 : st_d.a_vel;
            st_d.s_err  = 1'b1;
            st_d.s_code = bad_code;
            st_d.s_done = 1'b0;
            st_d.s_abt  = 1'b0;
        end else if (st_q.s_act && !st_q.ctrl[CTL_AXIS_EN]) begin
            // RQ11: axis dropped out while stopping
            st_d.s_busy = 1'b0;
            st_d.s_act  = 1'b0;
            st_d.s_err  = 1'b1;
            st_d.s_code = FC_DISABLED;
            // no ramp left to run, so the additive part must not drift
            st_d.a_vel  = '0;
        end else if (st_q.s_act && base_abort) begin
            // RQ8: another instruction takes the axis
            st_d.s_busy = 1'b0;
            st_d.s_act  = 1'b0;
            st_d.s_abt  = 1'b1;
            st_d.a_vel  = '0;
        end else if (st_q.s_act) begin
            // RQ20: rate grows by jerk, capped at deceleration
            st_d.s_rate = (st_q.s_rate + st_q.s_jerk > st_q.s_dec) ?
                          st_q.s_dec : st_q.s_rate + st_q.s_jerk;
            st_d.a_vel  = (st_q.a_vel > DW'(st_q.s_rate)) ?
                          st_q.a_vel - DW'(st_q.s_rate) : '0;
            // RQ6: done replaces busy and active together
            if (st_q.a_vel == '0) begin
                st_d.s_busy = 1'b0;
                st_d.s_act  = 1'b0;
                st_d.s_done = 1'b1;
            end
        end

        // unbuffered base start also aborts a running additive move
        if (base_abort && st_q.a_act) begin
            st_d.a_busy = 1'b0;
            st_d.a_act  = 1'b0;
            st_d.a_abt  = 1'b1;
            st_d.a_vel  = '0;
            st_d.a_acc  = '0;
        end

        // fault code follows the error flag back to zero
        if (!st_d.s_err) begin
            st_d.s_code = FC_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; busy is early so it rises with the start edge
    // RQ4: busy combinational on the start edge
    assign stop_busy_o    = st_q.s_busy | stop_go;
    // RQ5: active mirrors control of the axis
    assign stop_active_o  = st_q.s_act;
    assign stop_done_o    = st_q.s_done;
    assign aborted_flag_o = st_q.s_abt;
    assign stop_error_o   = st_q.s_err;
    assign fault_code_o   = st_q.s_code;
    assign cmd_position_o = st_q.pos;
    assign cmd_velocity_o = st_q.a_vel + st_q.b_vel;
    assign dat_o          = st_q.rdat;
    assign ack_o          = st_q.ack;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_active_after_go: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_go |-> stop_busy_o ##1 (stop_active_o && stop_busy_o)) // RQ4
        else $error("active not one cycle after start");

    a_done_drops_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(stop_done_o) |-> !stop_busy_o && !stop_active_o) // RQ6
        else $error("done with busy or active still set");

    a_done_pulse_low: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_done_o && !stop_ex |=> !stop_done_o) // RQ7
        else $error("done held after start fell");

    a_abort_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        aborted_flag_o && !stop_ex |=> !aborted_flag_o) // RQ9
        else $error("aborted held after start fell");

    a_abort_drops: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(aborted_flag_o) |-> !stop_busy_o && !stop_active_o) // RQ8
        else $error("aborted with busy or active set");

    a_error_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_error_o && stop_ex && !stop_rise |=> stop_error_o) // RQ10
        else $error("error dropped while start high");

    a_error_code: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_error_o |-> fault_code_o != FC_NONE) // RQ12
        else $error("error without a fault code");

    a_no_move_err: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_rise && !base_abort && !st_q.a_busy |=>
        stop_error_o && !stop_active_o) // RQ13
        else $error("stop acted without an additive move");

    a_add_aborted: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(stop_active_o) |-> st_q.a_abt && !st_q.a_busy) // RQ19
        else $error("additive move not aborted on activation");

    a_base_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_go && st_q.b_act |=> st_q.b_done ||
        st_q.b_vel == $past(st_q.b_vel) + $past(st_q.b_acc)) // RQ14
        else $error("base move disturbed by stop");

    a_vel_decays: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_active_o && $past(stop_active_o) |->
        st_q.a_vel <= $past(st_q.a_vel)) // RQ20
        else $error("additive velocity rose while stopping");

    a_disabled_err: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_active_o && !st_q.ctrl[CTL_AXIS_EN] && !stop_rise |=>
        stop_error_o && !stop_active_o) // RQ11
        else $error("disabled axis not flagged");
endmodule
`default_nettype wire

// >>> program_master.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// user program side: one wishbone access per request
module program_master (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [31:0] wdat_i,
    output logic             done_o,
    output logic      [31:0] rdat_o,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             wb_we_o,
    output logic      [5:0]  wb_adr_o,
    output logic      [31:0] wb_dat_o,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i
);
    ////////////////////////////////////////
    // request held until ack; released address and data lines are inverted, write enable keeps its value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_o  <= 1'b0;
            stb_o  <= 1'b0;
            done_o <= 1'b0;
        end else if (cyc_o && ack_i) begin
            cyc_o    <= 1'b0;
            stb_o    <= 1'b0;
            done_o   <= 1'b1;
            rdat_o   <= dat_i;
            wb_adr_o <= ~wb_adr_o;
            wb_dat_o <= ~wb_dat_o;
        end else if (req_i && !cyc_o && !done_o) begin
            cyc_o    <= 1'b1;
            stb_o    <= 1'b1;
            wb_we_o  <= we_i;
            wb_adr_o <= adr_i;
            wb_dat_o <= wdat_i;
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> additive_move_stop_tb.sv
`timescale 1ns/1ps
`default_nettype none
module additive_move_stop_tb;
    import stop_ctrl_pkg::*;
    localparam logic [31:0] EN = 32'h0000_0108; // axis 1, enabled
    logic        clk, rst, req, we, done, cyc, stb, wb_we, ack;
    logic        busy, active, sdone, abt, err;
    logic [5:0]  adr, wb_adr;
    logic [31:0] wdat, rdat, wb_dat, dat_o, pos, vel, r;
    logic [15:0] fc;
    int          bad_count = 0;
    int          checks_done = 0;
    // fault table: control word, decel, jerk, expected code
    logic [31:0] tc [6] = '{32'h8, 32'h2108, EN, EN, 32'h100, EN};
    logic [31:0] td [6] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'h1, 32'h1};
    logic [31:0] tj [6] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h1, 32'h1};
    logic [15:0] tf [6] = '{16'h1, 16'h1, 16'h2, 16'h2, 16'h3, 16'h4};

    // edge monitor: the bus tasks return too late to see these directly
    int          cyc_n = 0;
    int          busy_at = 0;
    int          act_at = 0;
    int          abt_n = 0;
    int          n0;
    logic        busy_p = 1'b0;
    logic        act_p = 1'b0;
    always @(posedge clk) begin
        cyc_n  <= cyc_n + 1;
        busy_p <= busy;
        act_p  <= active;
        if (busy && !busy_p) busy_at <= cyc_n;
        if (active && !act_p) act_at <= cyc_n;
        if (abt) abt_n <= abt_n + 1;
    end

    // one cycle is one scan cycle
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    program_master pm (.clk_i(clk), .rst_i(rst), .req_i(req), .we_i(we),
        .adr_i(adr), .wdat_i(wdat), .done_o(done), .rdat_o(rdat),
        .cyc_o(cyc), .stb_o(stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
        .wb_dat_o(wb_dat), .ack_i(ack), .dat_i(dat_o));
    additive_move_stop dut (.clk_i(clk), .rst_i(rst), .adr_i(wb_adr),
        .dat_i(wb_dat), .dat_o(dat_o), .we_i(wb_we), .sel_i(4'hf),
        .stb_i(stb), .cyc_i(cyc), .ack_o(ack), .stop_busy_o(busy),
        .stop_active_o(active), .stop_done_o(sdone), .aborted_flag_o(abt),
        .stop_error_o(err), .fault_code_o(fc), .cmd_position_o(pos),
        .cmd_velocity_o(vel));

    ////////////////////////////////////////
    // compares, bus access and waits
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (done !== 1'b1);
        req <= 1'b0;
        r = rdat;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a);
        wb(1'b0, a, 32'h0);
    endtask
    // bounded poll, so a stuck register ends as a mismatch
    task automatic poll(input logic [5:0] a, input logic [31:0] m, v);
        for (int i = 0; i < 400; i++) begin
            rd(a);
            if ((r & m) === v) break;
        end
        chk_w(r & m, v);
    endtask
    function automatic logic flag(input int k);
        case (k)
            0: return busy;
            1: return active;
            2: return sdone;
            3: return abt;
            default: return err;
        endcase
    endfunction
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic wait_flag(input int k);
        for (int i = 0; i < 400; i++) begin
            step;
            if (flag(k) === 1'b1) break;
        end
        chk_b(flag(k), 1'b1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog: whole run needs several hundred cycles
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        tally_and_finish;
    end

    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        req = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        wdat = 32'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // reset state, unmapped and read-only places
        rd(OFS_STATUS); chk_w(r, 32'h0);
        rd(OFS_FAULT); chk_w(r, 32'h0);
        rd(6'h30); chk_w(r, 32'h0);
        wr(OFS_STATUS, 32'hffff_ffff); rd(OFS_STATUS); chk_w(r, 32'h0);
        wr(OFS_DECEL, 32'h1); wr(OFS_JERK, 32'h1); rd(OFS_JERK); chk_w(r, 32'h1);
        // joint moves without a stop
        wr(OFS_ADD_DIST, 32'd20); wr(OFS_ADD_VEL, 32'd3);
        wr(OFS_BASE_DIST, 32'd400); wr(OFS_BASE_VEL, 32'd4);
        // base first: an unbuffered base start cancels an additive start
        wr(OFS_CTRL, EN); wr(OFS_CTRL, EN | 32'h4); wr(OFS_CTRL, EN | 32'h6);
        poll(OFS_STATUS, 32'h20, 32'h20);
        chk_w(r & 32'h400, 32'h400);
        poll(OFS_STATUS, 32'h200, 32'h200);
        rd(OFS_POSITION); chk_w(r, 32'd420);
        // stop while both move: handshake, base untouched
        wr(OFS_ADD_DIST, 32'd2000); wr(OFS_ADD_VEL, 32'd20);
        wr(OFS_BASE_DIST, 32'd8000);
        wr(OFS_CTRL, EN); wr(OFS_CTRL, EN | 32'h4); wr(OFS_CTRL, EN | 32'h6);
        poll(OFS_VELOCITY, 32'hffff_ffff, 32'd24);
        wr(OFS_CTRL, EN | 32'h7);
        wait_flag(0); chk_w(act_at - busy_at, 32'd1);
        step; chk_b(active, 1'b1);
        rd(OFS_STATUS); chk_w(r & 32'h540, 32'h500);
        wait_flag(2); chk_b(busy, 1'b0); chk_b(active, 1'b0);
        chk_w(vel, 32'd4);
        repeat (3) step;
        chk_b(sdone, 1'b1);
        wr(OFS_CTRL, EN | 32'h4); step; chk_b(sdone, 1'b0);
        // start falls before the stop completes
        wr(OFS_CTRL, EN | 32'h6);
        poll(OFS_VELOCITY, 32'hffff_ffff, 32'd24);
        wr(OFS_CTRL, EN | 32'h7); wr(OFS_CTRL, EN | 32'h6);
        wait_flag(2); chk_b(busy, 1'b0);
        step; chk_b(sdone, 1'b0);
        // unbuffered base start aborts a running stop
        wr(OFS_CTRL, EN); wr(OFS_CTRL, EN | 32'h2);
        poll(OFS_VELOCITY, 32'hffff_ffff, 32'd24);
        wr(OFS_CTRL, EN | 32'h3); wait_flag(1);
        wr(OFS_CTRL, EN | 32'h7);
        wait_flag(3); chk_b(busy, 1'b0); chk_b(active, 1'b0);
        repeat (3) step;
        chk_b(abt, 1'b1);
        wr(OFS_CTRL, EN | 32'h6); step; chk_b(abt, 1'b0);
        // abort after the start already fell
        wr(OFS_CTRL, EN); wr(OFS_CTRL, EN | 32'h2);
        poll(OFS_VELOCITY, 32'hffff_ffff, 32'd24);
        wr(OFS_CTRL, EN | 32'h3); wait_flag(1);
        wr(OFS_CTRL, EN | 32'h2); n0 = abt_n; wr(OFS_CTRL, EN | 32'h6);
        repeat (2) step;
        chk_w(abt_n - n0, 32'd1); chk_b(abt, 1'b0);
        // axis disabled while the stop runs
        wr(OFS_CTRL, EN | 32'h4); wr(OFS_CTRL, EN | 32'h6);
        poll(OFS_VELOCITY, 32'hffff_ffff, 32'd24);
        wr(OFS_CTRL, EN | 32'h7); wait_flag(1);
        wr(OFS_CTRL, 32'h107); wait_flag(4);
        chk_w({16'h0, fc}, 32'h3); chk_b(active, 1'b0);
        chk_b(busy, 1'b0);
        // illegal parameters, disabled axis, no additive move
        for (int i = 0; i < 6; i++) begin
            wr(OFS_DECEL, td[i]); wr(OFS_JERK, tj[i]);
            wr(OFS_CTRL, tc[i]); wr(OFS_CTRL, tc[i] | 32'h1);
            wait_flag(4); chk_w({16'h0, fc}, {16'h0, tf[i]});
            chk_b(busy, 1'b0);
            repeat (3) step;
            chk_b(err, 1'b1);
            wr(OFS_CTRL, tc[i]); step; chk_b(err, 1'b0);
            chk_w({16'h0, fc}, 32'h0);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
